/* File: cfp_ctrl.sv */
// cfp_ctrl: per-channel comparator mode logic, window flags, fault dump into
// two emulated NVM rows, row read-back window and safe-state sequencer.
// assumes an analog comparator per channel reporting input above cmp_ref_o,
// asynchronous pins, and an Avalon-MM master on clk_i.
//
// Contract
// - mode field: 00 plain, 01 hysteresis, 10 window, 11 invalid.
// - hysteresis thresholds come from the channel's high and low margin codes.
// - high margin full or low margin zero makes hysteresis comparator latch.
// - per-channel flag reset bit releases a latched comparator output.
// - window mode uses high and low margin codes as window bounds.
// - each channel's window result sits in its own flags register bit.
// - with window hold enabled, a set window result stays set until reset.
// - reset clears a held window bit only while the input is inside.
// - one comparator alternates high and low limits, giving finite latency.
// - window result never drives the channel pin; register or GPIO only.
// - dump request from bit or pin stores flags byte and code upper bytes.
// - row 1 holds flags in bits 31:24; row 2 codes ch0..ch3 top down.
// - row select 0 reads back row 1, 1 reads back row 2.
// - copy strobe moves selected row to SRAM 0x9D low, 0x9E high; self-clears.
// - all channels start in high-impedance power-down after reset.
// - safe state starts from its pin or a software trigger bit.
// - safe action 00 off, 01 NVM code, 10 slew low, 11 slew high; then off.
// - register writes are ignored while the safe-state function runs.
// - safe flag sets on trigger; flags read after completion clears it.
`timescale 1ns/1ps

module cfp_ctrl
   import cfp_pkg::*;
#(
   parameter int NVM_WR_CYCLES = NVM_WR_CYC
) (
   input  wire logic                               clk_i,
   input  wire logic                               rst_n_i,
   input  wire logic [7:0]                         avs_address_i,
   input  wire logic                               avs_read_i,
   input  wire logic                               avs_write_i,
   input  wire logic [31:0]                        avs_writedata_i,
   input  wire logic [3:0]                         avs_byteenable_i,
   output logic      [31:0]                        avs_readdata_o,
   output logic      [1:0]                         avs_response_o,
   output logic                                    avs_waitrequest_o,
   input  wire logic [NCH-1:0]                     cmp_hit_i,
   input  wire logic                               gpio_safe_i,
   input  wire logic                               gpio_dump_i,
   output logic      [NCH-1:0][CODE_W-1:0]         cmp_ref_o,
   output logic      [NCH-1:0]                     cmp_pin_o,
   output logic      [NCH-1:0]                     cmp_pin_en_o,
   output logic                                    gpio_win_o,
   output cfp_chan_out_t [NCH-1:0]                 chan_o
);

   typedef enum logic [1:0] {SF_IDLE, SF_SLEW, SF_OFF} cfp_safe_st_t;
   typedef enum logic [1:0] {DP_IDLE, DP_ROW1, DP_ROW2} cfp_dump_st_t;

   // bus handshake and registers
   logic                   wait_r;
   logic [31:0]            rdata_r;
   logic [1:0]             resp_r;
   logic [CFG_W-1:0]       cfg_r;
   logic [CODE_W-1:0]      mhi_r [NCH];
   logic [CODE_W-1:0]      mlo_r [NCH];
   logic [CODE_W-1:0]      code_r [NCH];
   logic [CODE_W-1:0]      nvm_code_r;
   logic [15:0]            sram_ptr_r;
   logic [15:0]            sram_r [2];
   logic [31:0]            nvm_row_r [2];
   logic                   safe_flag_r;
   cfp_safe_st_t           safe_st_r;
   logic [15:0]            slew_cnt_r;
   cfp_dump_st_t           dump_st_r;
   logic [31:0]            dump_cnt_r;

   // per-channel comparator state
   logic [CODE_W-1:0]      ref_r [NCH];
   logic [7:0]             settle_r [NCH];
   logic [NCH-1:0]         phase_r;
   logic [NCH-1:0]         out_r;
   logic [NCH-1:0]         latch_r;
   logic [NCH-1:0]         above_r;
   logic [NCH-1:0]         below_r;
   logic [NCH-1:0]         win_r;
   logic [NCH-1:0]         pin_r;
   logic [NCH-1:0]         pin_en_r;
   logic                   gpio_win_r;

   // pin synchronisers: s1 feeds only s2
   logic [NCH+1:0]         sync1_r;
   logic [NCH+1:0]         sync2_r;
   logic [NCH+1:0]         sync3_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= {gpio_dump_i, gpio_safe_i, cmp_hit_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   wire [NCH-1:0] hit       = sync2_r[NCH-1:0];
   wire           safe_edge = sync2_r[NCH] & ~sync3_r[NCH];
   wire           dump_edge = sync2_r[NCH+1] & ~sync3_r[NCH+1];

   // bus decode
   wire        rd_acc   = avs_read_i & ~wait_r;
   wire        wr_acc   = avs_write_i & ~wait_r;
   wire        safe_busy = (safe_st_r != SF_IDLE);
   wire        wr_ok    = wr_acc & ~safe_busy;
   wire [31:0] be_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                           {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   wire [31:0] wd_m     = avs_writedata_i & be_mask;
   wire [1:0]  ch_idx   = avs_address_i[3:2];
   wire        sel_cfg  = (avs_address_i == A_CFG);
   wire        sel_trig = (avs_address_i == A_TRIG);
   wire        sel_flg  = (avs_address_i == A_FLAGS);
   wire        sel_ptr  = (avs_address_i == A_SRAM_PTR);
   wire        sel_dat  = (avs_address_i == A_SRAM_DATA);
   wire        sel_nvm  = (avs_address_i == A_NVM_CODE);
   wire        sel_mhi  = (avs_address_i[7:4] == A_MHI[7:4]) && (avs_address_i[1:0] == 2'b00);
   wire        sel_mlo  = (avs_address_i[7:4] == A_MLO[7:4]) && (avs_address_i[1:0] == 2'b00);
   wire        sel_code = (avs_address_i[7:4] == A_CODE[7:4]) && (avs_address_i[1:0] == 2'b00);
   wire        mapped   = sel_cfg | sel_trig | sel_flg | sel_ptr | sel_dat | sel_nvm |
                          sel_mhi | sel_mlo | sel_code;

   // trigger strobes exist for one cycle only and are never stored
   wire [NCH-1:0] clr_stb  = {NCH{wr_ok & sel_trig}} & wd_m[TRG_CLR_LSB +: NCH];
   wire           copy_stb = wr_ok & sel_trig & wd_m[TRG_COPY];
   wire           dump_trig = (wr_ok & sel_trig & wd_m[TRG_DUMP]) | dump_edge;
   wire           safe_trig = ~safe_busy &
                              ((wr_ok & sel_trig & wd_m[TRG_SAFE]) | safe_edge);

   wire        hold_en  = cfg_r[CFG_HOLD];
   wire        row_sel  = cfg_r[CFG_ROW];
   wire [1:0]  safe_act = cfg_r[CFG_SAFE_LSB +: 2];

   wire [31:0] flags_w  = {21'h0, safe_busy, (dump_st_r != DP_IDLE), safe_flag_r,
                           out_r, win_r};
   wire [15:0] sram_rd  = (sram_ptr_r == SRAM_LO_ADDR) ? sram_r[0] :
                          (sram_ptr_r == SRAM_HI_ADDR) ? sram_r[1] : 16'h0000;
   wire [31:0] rd_mux   = sel_cfg  ? {12'h000, cfg_r} :
                          sel_flg  ? flags_w :
                          sel_ptr  ? {16'h0000, sram_ptr_r} :
                          sel_dat  ? {16'h0000, sram_rd} :
                          sel_nvm  ? {16'h0000, nvm_code_r} :
                          sel_mhi  ? {16'h0000, mhi_r[ch_idx]} :
                          sel_mlo  ? {16'h0000, mlo_r[ch_idx]} :
                          sel_code ? {16'h0000, code_r[ch_idx]} : 32'h0000_0000;

   // one wait state: waitrequest drops for exactly one cycle per access
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0000_0000;
         resp_r  <= RESP_OK;
      end else begin
         wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
         if ((avs_read_i | avs_write_i) & wait_r) begin
            rdata_r <= avs_read_i ? rd_mux : 32'h0000_0000;
            resp_r  <= mapped ? RESP_OK : RESP_DECERR;
         end
      end
   end

   // safe-state slew targets
   logic [NCH-1:0] at_tgt;
   logic [CODE_W-1:0] tgt [NCH];
   for (genvar c = 0; c < NCH; c++) begin : g_tgt
      assign tgt[c]    = (safe_act == SAFE_LOW) ? mlo_r[c] : mhi_r[c];
      assign at_tgt[c] = (code_r[c] == tgt[c]);
   end

   // register file and safe-state sequencer share the code and power bits
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_r      <= CFG_RST;
         nvm_code_r <= CODE_ZERO;
         sram_ptr_r <= 16'h0000;
         safe_flag_r <= 1'b0;
         safe_st_r  <= SF_IDLE;
         slew_cnt_r <= 16'h0000;
         for (int i = 0; i < NCH; i++) begin
            mhi_r[i]  <= CODE_ZERO;
            mlo_r[i]  <= CODE_ZERO;
            code_r[i] <= CODE_ZERO;
         end
      end else begin
         if (wr_ok & sel_cfg) begin
            cfg_r <= (cfg_r & ~be_mask[CFG_W-1:0]) | wd_m[CFG_W-1:0];
         end
         if (wr_ok & sel_nvm) begin
            nvm_code_r <= (nvm_code_r & ~be_mask[15:0]) | wd_m[15:0];
         end
         if (wr_ok & sel_ptr) begin
            sram_ptr_r <= (sram_ptr_r & ~be_mask[15:0]) | wd_m[15:0];
         end
         if (wr_ok & sel_mhi) begin
            mhi_r[ch_idx] <= (mhi_r[ch_idx] & ~be_mask[15:0]) | wd_m[15:0];
         end
         if (wr_ok & sel_mlo) begin
            mlo_r[ch_idx] <= (mlo_r[ch_idx] & ~be_mask[15:0]) | wd_m[15:0];
         end
         if (wr_ok & sel_code) begin
            code_r[ch_idx] <= (code_r[ch_idx] & ~be_mask[15:0]) | wd_m[15:0];
         end
         // flag clears on a flags read after completion; a new trigger wins
         if (safe_trig) begin
            safe_flag_r <= 1'b1;
         end else if (rd_acc & sel_flg & ~safe_busy) begin
            safe_flag_r <= 1'b0;
         end
         case (safe_st_r)
            SF_IDLE: begin
               if (safe_trig) begin
                  slew_cnt_r <= 16'(SLEW_CYC - 1);
                  case (safe_act)
                     SAFE_HIZ: safe_st_r <= SF_OFF;
                     SAFE_NVM: begin
                        for (int i = 0; i < NCH; i++) code_r[i] <= nvm_code_r;
                        safe_st_r <= SF_OFF;
                     end
                     default:  safe_st_r <= SF_SLEW;
                  endcase
               end
            end
            SF_SLEW: begin
               if (&at_tgt) begin
                  safe_st_r <= SF_OFF;
               end else if (slew_cnt_r == 16'h0000) begin
                  slew_cnt_r <= 16'(SLEW_CYC - 1);
                  for (int i = 0; i < NCH; i++) begin
                     if (code_r[i] < tgt[i]) code_r[i] <= code_r[i] + 16'h0001;
                     else if (code_r[i] > tgt[i]) code_r[i] <= code_r[i] - 16'h0001;
                  end
               end else begin
                  slew_cnt_r <= slew_cnt_r - 16'h0001;
               end
            end
            SF_OFF: begin
               cfg_r[CFG_PDN_LSB +: NCH] <= {NCH{1'b1}};
               safe_st_r <= SF_IDLE;
            end
            default: safe_st_r <= SF_IDLE;
         endcase
      end
   end

   // fault dump into two rows, each committed after one NVM write time
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dump_st_r    <= DP_IDLE;
         dump_cnt_r   <= 32'h0000_0000;
         nvm_row_r[0] <= 32'h0000_0000;
         nvm_row_r[1] <= 32'h0000_0000;
         sram_r[0]    <= 16'h0000;
         sram_r[1]    <= 16'h0000;
      end else begin
         if (copy_stb) begin
            sram_r[0] <= nvm_row_r[row_sel][15:0];
            sram_r[1] <= nvm_row_r[row_sel][31:16];
         end
         case (dump_st_r)
            DP_IDLE: begin
               if (dump_trig) begin
                  dump_st_r  <= DP_ROW1;
                  dump_cnt_r <= 32'(NVM_WR_CYCLES - 1);
               end
            end
            DP_ROW1: begin
               if (dump_cnt_r == 32'h0000_0000) begin
                  nvm_row_r[0] <= {flags_w[7:0], 24'h000000};
                  dump_st_r    <= DP_ROW2;
                  dump_cnt_r   <= 32'(NVM_WR_CYCLES - 1);
               end else begin
                  dump_cnt_r <= dump_cnt_r - 32'h0000_0001;
               end
            end
            DP_ROW2: begin
               if (dump_cnt_r == 32'h0000_0000) begin
                  nvm_row_r[1] <= {code_r[0][15:8], code_r[1][15:8],
                                   code_r[2][15:8], code_r[3][15:8]};
                  dump_st_r    <= DP_IDLE;
               end else begin
                  dump_cnt_r <= dump_cnt_r - 32'h0000_0001;
               end
            end
            default: dump_st_r <= DP_IDLE;
         endcase
      end
   end

   // per-channel comparator: ref change restarts the settle wait
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire [1:0]        mode    = cfg_r[CFG_MODE_LSB + 2*c +: 2];
      wire              is_win  = (mode == CMP_WINDOW);
      wire [CODE_W-1:0] thr_nxt = is_win ? (phase_r[c] ? mlo_r[c] : mhi_r[c]) :
                                  (mode == CMP_HYST) ? (out_r[c] ? mlo_r[c] : mhi_r[c]) :
                                  code_r[c];
      wire              ready   = (settle_r[c] == 8'h00) && (ref_r[c] == thr_nxt);
      wire              lat_cnd = (mode == CMP_HYST) &&
                                  ((mhi_r[c] == CODE_FULL) || (mlo_r[c] == CODE_ZERO));
      wire              outside = above_r[c] | below_r[c];

      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            ref_r[c]    <= CODE_ZERO;
            settle_r[c] <= 8'h00;
            phase_r[c]  <= 1'b0;
            out_r[c]    <= 1'b0;
            latch_r[c]  <= 1'b0;
            above_r[c]  <= 1'b0;
            below_r[c]  <= 1'b0;
            win_r[c]    <= 1'b0;
            pin_r[c]    <= 1'b0;
            pin_en_r[c] <= 1'b0;
         end else begin
            ref_r[c] <= thr_nxt;
            if (ref_r[c] != thr_nxt) begin
               settle_r[c] <= 8'(SETTLE_CYC);
            end else if (settle_r[c] != 8'h00) begin
               settle_r[c] <= settle_r[c] - 8'h01;
            end
            if (clr_stb[c]) latch_r[c] <= 1'b0;
            if (ready) begin
               case (mode)
                  CMP_NORMAL: out_r[c] <= hit[c];
                  CMP_HYST: begin
                     // a latched output ignores crossings until released
                     if (!latch_r[c] && (out_r[c] != hit[c])) begin
                        out_r[c]   <= hit[c];
                        latch_r[c] <= lat_cnd;
                     end
                  end
                  CMP_WINDOW: begin
                     phase_r[c] <= ~phase_r[c];
                     if (!phase_r[c]) above_r[c] <= hit[c];
                     else below_r[c] <= ~hit[c];
                  end
                  default: out_r[c] <= 1'b0;
               endcase
            end
            if (!is_win) begin
               win_r[c] <= 1'b0;
            end else if (hold_en) begin
               win_r[c] <= (win_r[c] & ~(clr_stb[c] & ~outside)) | outside;
            end else begin
               win_r[c] <= outside;
            end
            // window result stays off the pin even with drive enabled
            pin_r[c]    <= out_r[c] & ~is_win;
            pin_en_r[c] <= cfg_r[CFG_DRV_LSB + c] & ~is_win;
         end
      end

      assign cmp_ref_o[c]   = ref_r[c];
      assign chan_o[c].pdn  = cfg_r[CFG_PDN_LSB + c];
      assign chan_o[c].code = code_r[c];
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gpio_win_r <= 1'b0;
      end else begin
         gpio_win_r <= |win_r;
      end
   end

   assign avs_readdata_o    = rdata_r;
   assign avs_response_o    = resp_r;
   assign avs_waitrequest_o = wait_r;
   assign cmp_pin_o         = pin_r;
   assign cmp_pin_en_o      = pin_en_r;
   assign gpio_win_o        = gpio_win_r;

endmodule // cfp_ctrl

/* File: cfp_pkg.sv */
// cfp_pkg: register map, field positions, codes and timing counts of the
// comparator / fault-dump / safe-state controller.
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package cfp_pkg;

   localparam int NCH    = 4;
   localparam int CODE_W = 16;

   // register byte offsets
   localparam logic [7:0] A_CFG       = 8'h00;
   localparam logic [7:0] A_TRIG      = 8'h04;
   localparam logic [7:0] A_FLAGS     = 8'h08;
   localparam logic [7:0] A_SRAM_PTR  = 8'h0C;
   localparam logic [7:0] A_SRAM_DATA = 8'h10;
   localparam logic [7:0] A_NVM_CODE  = 8'h14;
   localparam logic [7:0] A_MHI       = 8'h20;   // +4 per channel
   localparam logic [7:0] A_MLO       = 8'h30;   // +4 per channel
   localparam logic [7:0] A_CODE      = 8'h40;   // +4 per channel

   // common configuration fields
   localparam int CFG_MODE_LSB = 0;    // 2 bits per channel
   localparam int CFG_HOLD     = 8;    // window_hold_enable
   localparam int CFG_ROW      = 9;    // nvm_row_select
   localparam int CFG_SAFE_LSB = 10;   // 2-bit safe-state action
   localparam int CFG_DRV_LSB  = 12;   // cmp_pin_drive_enable, 1 per channel
   localparam int CFG_PDN_LSB  = 16;   // power-down, 1 per channel
   localparam int CFG_W        = 20;
   localparam logic [CFG_W-1:0] CFG_RST = 20'hF0000;

   // dac_trigger_reg strobes
   localparam int TRG_CLR_LSB = 0;     // cmp_flag_clear, 1 per channel
   localparam int TRG_DUMP    = 4;
   localparam int TRG_COPY    = 5;     // row_copy_strobe
   localparam int TRG_SAFE    = 6;

   // comparator_flags_reg: [3:0] window_result, [7:4] comparator outputs
   localparam int FLG_SAFE      = 8;
   localparam int FLG_DUMP_BUSY = 9;
   localparam int FLG_SAFE_BUSY = 10;

   typedef enum logic [1:0] {
      CMP_NORMAL  = 2'b00,
      CMP_HYST    = 2'b01,
      CMP_WINDOW  = 2'b10,
      CMP_INVALID = 2'b11
   } cfp_cmp_mode_t;

   typedef enum logic [1:0] {
      SAFE_HIZ  = 2'b00,
      SAFE_NVM  = 2'b01,
      SAFE_LOW  = 2'b10,
      SAFE_HIGH = 2'b11
   } cfp_safe_act_t;

   localparam logic [15:0] SRAM_LO_ADDR = 16'h009D;
   localparam logic [15:0] SRAM_HI_ADDR = 16'h009E;
   localparam logic [CODE_W-1:0] CODE_FULL = 16'hFFFF;
   localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;

   localparam logic [1:0] RESP_OK     = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   // timing
   localparam int CLK_NS       = 10;
   localparam int SETTLE_NS    = 200;    // comparator settle after ref change
   localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLEW_STEP_NS = 4000;   // one code step per period
   localparam int SLEW_CYC     = (SLEW_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int NVM_WR_NS    = 1000000;
   localparam int NVM_WR_CYC   = NVM_WR_NS / CLK_NS;

   typedef struct packed {
      logic              pdn;    // 1: high-impedance power-down
      logic [CODE_W-1:0] code;
   } cfp_chan_out_t;

endpackage

/* File: cfp_ctrl_asserts.sv */
// cfp_ctrl_asserts: bus handshake, reset and strobe checks on cfp_ctrl ports.
// assumes one clock domain; bound into every cfp_ctrl instance.
`timescale 1ns/1ps
module cfp_ctrl_asserts
   import cfp_pkg::*;
(
   input wire logic                 clk_i,
   input wire logic                 rst_n_i,
   input wire logic [7:0]           avs_address_i,
   input wire logic                 avs_read_i,
   input wire logic                 avs_write_i,
   input wire logic [31:0]          avs_readdata_o,
   input wire logic [1:0]           avs_response_o,
   input wire logic                 avs_waitrequest_o,
   input wire cfp_chan_out_t [NCH-1:0] chan_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic req_w = avs_read_i | avs_write_i;
   sequence s_ack;
      !avs_waitrequest_o;
   endsequence
   sequence s_rd_ack(logic [7:0] a);
      s_ack ##0 (avs_read_i && avs_address_i == a);
   endsequence
   wait_one_a: assert property (s_ack |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   wait_answer_a: assert property ($rose(req_w) |=> s_ack)
      else $error("no answer one cycle after request");
   ack_req_a: assert property (s_ack |-> req_w)
      else $error("answer without request");
   reset_state_a: assert property ($rose(rst_n_i) |-> avs_waitrequest_o &&
      chan_o[0].pdn && chan_o[1].pdn && chan_o[2].pdn && chan_o[3].pdn)
      else $error("outputs not idle and powered down after reset");
   unmapped_resp_a: assert property (s_rd_ack(8'hFC) |->
      avs_response_o == RESP_DECERR && avs_readdata_o == 32'h0)
      else $error("unmapped read not refused");
   mapped_ok_a: assert property (s_rd_ack(A_FLAGS) |-> avs_response_o == RESP_OK)
      else $error("mapped read refused");
   trig_zero_a: assert property (s_rd_ack(A_TRIG) |-> avs_readdata_o == 32'h0)
      else $error("trigger register reads nonzero");
   rdata_hold_a: assert property (avs_waitrequest_o && $past(avs_waitrequest_o)
      |-> $stable(avs_readdata_o) && $stable(avs_response_o))
      else $error("read answer changed between accesses");
endmodule // cfp_ctrl_asserts

bind cfp_ctrl cfp_ctrl_asserts u_chk (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o, .chan_o);

/* File: cfp_cmp_model.sv */
// cfp_cmp_model: behavioural analog comparators, one per channel.
// assumes level_i is the sensed input expressed as a code.
`timescale 1ns/1ps
module cfp_cmp_model
   import cfp_pkg::*;
(
   input  wire logic [NCH-1:0][CODE_W-1:0] ref_i,
   input  wire logic [NCH-1:0][CODE_W-1:0] level_i,
   output logic      [NCH-1:0]             hit_o
);
   always_comb for (int c = 0; c < NCH; c++) hit_o[c] = level_i[c] > ref_i[c];
endmodule // cfp_cmp_model

/* File: cfp_ctrl_tb_top.sv */
// cfp_ctrl_tb_top: directed checks of window flags, fault dump, row
// read-back and safe-state actions. assumes cfp_ctrl and cfp_cmp_model.
`timescale 1ns/1ps
module cfp_ctrl_tb_top
   import cfp_pkg::*;
;
   logic clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, wq, win;
   logic g_safe = 1'b0, g_dump = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [1:0] resp;
   logic [NCH-1:0] hit, pin, pin_en;
   logic [NCH-1:0][CODE_W-1:0] cref, lvl = '0;
   cfp_chan_out_t [NCH-1:0] chan;
   int num_errors = 0, n_compared = 0, cyc = 0;

   always #5 clk_i = ~clk_i;
   cfp_ctrl #(.NVM_WR_CYCLES(10)) dut (.clk_i, .rst_n_i, .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_response_o(resp),
      .avs_waitrequest_o(wq), .cmp_hit_i(hit), .gpio_safe_i(g_safe),
      .gpio_dump_i(g_dump), .cmp_ref_o(cref), .cmp_pin_o(pin),
      .cmp_pin_en_o(pin_en), .gpio_win_o(win), .chan_o(chan));
   cfp_cmp_model u_cmp (.ref_i(cref), .level_i(lvl), .hit_o(hit));

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // request held until the edge that samples waitrequest low
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk_i);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk_i); while (wq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic w(logic [7:0] a, logic [31:0] d); bus(1'b1, a, d); endtask
   task automatic r(logic [7:0] a); bus(1'b0, a, 32'h0); endtask
   task automatic settle(); repeat (6 * (SETTLE_CYC + 3)) @(posedge clk_i); endtask
   function automatic logic [31:0] pdns();
      return {28'h0, chan[3].pdn, chan[2].pdn, chan[1].pdn, chan[0].pdn};
   endfunction

   task automatic t_reset();
      r(A_CFG);
      chk("cfg", {12'h0, CFG_RST}, q);
      chk("pdn", 32'hF, pdns());
      r(A_TRIG);
      chk("trig", 32'h0, q);
      r(8'hFC);
      chk("unmapped", {30'h0, RESP_DECERR}, {30'h0, resp});
   endtask
   task automatic t_window();
      w(A_MHI, 32'h8000);
      w(A_MLO, 32'h4000);
      lvl[0] <= 16'h6000;
      w(A_CFG, 32'hF1102); // ch0 window, hold, pin drive
      settle();
      r(A_FLAGS);
      chk("win inside", 32'h0, {31'h0, q[0]});
      lvl[0] <= 16'h9000;
      settle();
      r(A_FLAGS);
      chk("win outside", 32'h1, {31'h0, q[0]});
      chk("gpio win", 32'h1, {31'h0, win});
      chk("pin en", 32'h0, {31'h0, pin_en[0]});
      w(A_TRIG, 32'h1);
      lvl[0] <= 16'h6000;
      settle();
      r(A_FLAGS);
      chk("win held", 32'h1, {31'h0, q[0]});
      w(A_TRIG, 32'h1);
      r(A_FLAGS);
      chk("win cleared", 32'h0, {31'h0, q[0]});
      lvl[0] <= 16'h0000;
      w(A_CFG, 32'hF0000);
   endtask
   task automatic t_hyst();
      logic [15:0] lv [6] = '{16'h6000, 16'h9000, 16'h6000, 16'h3000, 16'h9000, 16'h0};
      logic [5:0] ex = 6'b110110;
      w(A_MHI + 8'h8, 32'h8000);
      w(A_MLO + 8'h8, 32'h4000);
      w(A_CFG, 32'hF4010); // ch2 hysteresis, pin drive
      for (int i = 0; i < 6; i++) begin
         if (i == 4) w(A_MLO + 8'h8, 32'h0);
         lvl[2] <= lv[i];
         settle();
         r(A_FLAGS);
         chk("hyst out", {31'h0, ex[i]}, {31'h0, q[6]});
         chk("hyst pin", {31'h0, ex[i]}, {31'h0, pin[2]});
         chk("hyst ref", ex[i] ? (i < 4 ? 32'h4000 : 32'h0) : 32'h8000, {16'h0, cref[2]});
      end
      w(A_TRIG, 32'h4);
      settle();
      r(A_FLAGS);
      chk("hyst clear", 32'h0, {31'h0, q[6]});
      lvl[2] <= 16'h0;
      w(A_CFG, 32'hF0000);
   endtask
   task automatic t_dump();
      lvl[1] <= 16'hFFFF;
      for (int c = 0; c < NCH; c++) w(A_CODE + 8'(4 * c), 32'h1234 + 32'h4444 * c);
      settle();
      w(A_TRIG, 32'h10);
      // codes and levels kept steady while busy
      do r(A_FLAGS); while (q[FLG_DUMP_BUSY] !== 1'b0);
      g_dump <= 1'b1;
      repeat (4) @(posedge clk_i);
      r(A_FLAGS);
      chk("pin dump", 32'h1, {31'h0, q[FLG_DUMP_BUSY]});
      do r(A_FLAGS); while (q[FLG_DUMP_BUSY] !== 1'b0);
      for (int row = 0; row < 2; row++) begin
         w(A_CFG, 32'hF0000 | 32'(row << CFG_ROW));
         w(A_TRIG, 32'h20);
         r(A_TRIG);
         chk("copy strobe", 32'h0, q);
         w(A_SRAM_PTR, {16'h0, SRAM_LO_ADDR});
         r(A_SRAM_DATA);
         chk("row low", row ? 32'h9ADF : 32'h0, q);
         w(A_SRAM_PTR, {16'h0, SRAM_HI_ADDR});
         r(A_SRAM_DATA);
         chk("row high", row ? 32'h1256 : 32'h2000, q);
      end
   endtask
   task automatic t_safe();
      int n;
      w(A_NVM_CODE, 32'h55);
      for (int a = 0; a < 4; a++) begin
         for (int c = 0; c < NCH; c++) begin
            w(A_MHI + 8'(4 * c), 32'h3);
            w(A_MLO + 8'(4 * c), 32'h0);
            w(A_CODE + 8'(4 * c), 32'h2);
         end
         w(A_CFG, 32'(a << CFG_SAFE_LSB));
         if (a == 0) g_safe <= 1'b1;
         else w(A_TRIG, 32'h40);
         if (a > 1) begin
            w(A_MHI + 8'h4, 32'h777);
            r(A_FLAGS);
            chk("busy flag", 32'h3, {30'h0, q[FLG_SAFE_BUSY], q[FLG_SAFE]});
         end
         // pin edge is seen three edges late
         repeat (5) @(posedge clk_i);
         n = 0;
         while (chan[0].pdn !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
         end
         repeat (4) @(posedge clk_i);
         r(A_FLAGS);
         chk("safe flag", 32'h1, {31'h0, q[FLG_SAFE]});
         chk("safe busy", 32'h0, {31'h0, q[FLG_SAFE_BUSY]});
         r(A_FLAGS);
         chk("flag clear", 32'h0, {31'h0, q[FLG_SAFE]});
         chk("safe pdn", 32'hF, pdns());
         if (a > 0) chk("safe code", a == 1 ? 32'h55 : (a == 2 ? 32'h0 : 32'h3),
            {16'h0, chan[0].code});
         r(A_MHI + 8'h4);
         chk("margin kept", 32'h3, q);
         g_safe <= 1'b0;
      end
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_window();
      t_hyst();
      t_dump();
      t_safe();
      tally_and_finish();
   end
endmodule // cfp_ctrl_tb_top
